// ==== core/sbc_misc_defines.vh ====
// constants for the setup and special-mode register block
`ifndef SBC_MISC_DEFINES_VH
`define SBC_MISC_DEFINES_VH
// command codes (bits 15..9 of the frame, parity bit 8 excluded); the random read is a whole 16-bit frame
`define CMD_MISC_SETUP 7'h28
`define CMD_SPECIAL_MODE 7'h29
`define CMD_RANDOM_READ 16'h1300
// misc_setup field positions
`define MISC_CODE_GATE 7
`define MISC_PARITY 6
`define MISC_INT_LEVEL 5
`define MISC_INT_SHORT 4
`define MISC_INT_FLASH 3
`define MISC_DBG_EN 2
`define MISC_RESET 8'h00
`define SPE_RESET 8'h00
// mode-select encodings
`define SEL_RESET 2'h0
`define SEL_INIT 2'h1
`define SEL_FLASH 2'h2
// device mode encodings
`define MODE_RESET 2'h0
`define MODE_INIT 2'h1
`define MODE_FLASH 2'h2
`define MODE_NORMAL 2'h3
// interrupt pulse times in ns and the clock period in ns
`define CLK_PERIOD_NS 4
`define INT_LONG_NS 100000
`define INT_SHORT_NS 25000
`define LFSR_SEED 8'h01
`endif

// ==== core/bit_sync.v ====
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire arst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // reset to the pin's idle level so no false edge follows reset
      stage1 <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // bit_sync
`default_nettype wire

// ==== core/sbc_misc_regs.v ====
// spi-programmed misc setup and secured special-mode registers
`timescale 1ns/1ns
`default_nettype none
`include "sbc_misc_defines.vh"
// Behaviour
// - setup register writable only in init mode
// - code gate bit requires code for low power
// - parity bit checked only when parity enabled
// - interrupt pulses, or holds low when level
// - pulse width 100us or 25us
// - flash mode interrupt at half watchdog period
// - debug field selects safe variant or disabled
// - resistor mismatch sets debug flag
// - programmed variant overrides detected resistor
// - mode select: reset, init, flash, invalid
// - special mode needs matching inverted random code
// - command 0x1300 returns six-bit random code
// - safe output activation with partly inverted code
module sbc_misc_regs #(
  parameter INT_LONG_CYC = `INT_LONG_NS / `CLK_PERIOD_NS,
  parameter INT_SHORT_CYC = `INT_SHORT_NS / `CLK_PERIOD_NS
) (
  input wire clk,
  input wire arst_n,
  input wire spiCs_n,
  input wire spiClk,
  input wire spiMosi,
  output reg spiMiso,
  input wire resetDone,
  input wire initExit,
  input wire lpRequest,
  input wire [2:0] lpCode,
  input wire intEvent,
  input wire intClear,
  input wire wdHalf,
  input wire [1:0] detectedRes,
  input wire dbgFlagClear,
  output reg lpEnter,
  output reg int_n,
  output reg safe_n,
  output reg dbgResFlag,
  output reg [1:0] safeVariant,
  output reg [1:0] deviceMode,
  output reg [7:0] miscSetup,
  output reg [7:0] specialMode
);
  wire [2:0] syncOut;
  reg sclkPrev;
  reg csPrev;
  reg [15:0] rxShift;
  reg [15:0] txShift;
  reg [4:0] bitCnt;
  reg frameDone;
  reg [15:0] frame;
  reg [7:0] lfsr;
  reg [5:0] pendingCode;
  reg [5:0] issuedCode;
  reg codeValid;
  reg [14:0] intCnt;
  reg intHeld;
  wire csS = syncOut[2];
  wire sclkS = syncOut[1];
  wire mosiS = syncOut[0];
  wire sclkRise = sclkS & ~sclkPrev & ~csS;
  wire sclkFall = ~sclkS & sclkPrev & ~csS;
  wire frameStart = ~csS & csPrev;
  wire frameEnd = csS & ~csPrev;
  // even parity over all sixteen bits
  wire parityOk = ~miscSetup[`MISC_PARITY] | ~(^frame);
  wire frameOk = frameDone & parityOk;
  wire miscWrite = frameOk & (frame[15:9] == `CMD_MISC_SETUP);
  wire speWrite = frameOk & (frame[15:9] == `CMD_SPECIAL_MODE);
  // parity guards writes only, so the code read is taken either way
  wire codeRead = frameDone & (frame == `CMD_RANDOM_READ);
  wire [1:0] sel = frame[7:6];
  wire modeMatch = codeValid & (frame[5:0] == ~issuedCode);
  wire safeMatch = codeValid & (frame[5:4] == issuedCode[5:4])
    & (frame[3:0] == ~issuedCode[3:0]);
  wire intReq = intEvent | (wdHalf & miscSetup[`MISC_INT_FLASH]
    & (deviceMode == `MODE_FLASH));
  wire [14:0] intWidth = miscSetup[`MISC_INT_SHORT] ? INT_SHORT_CYC[14:0]
    : INT_LONG_CYC[14:0];
  wire dbgEn = miscSetup[`MISC_DBG_EN];

  bit_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({spiCs_n, spiClk, spiMosi}),
    .dout(syncOut)
  );

  // spi shifter: sample on rising edge, launch on falling edge
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclkPrev <= 1'b0;
      csPrev <= 1'b1;
      rxShift <= 16'h0000;
      txShift <= 16'h0000;
      bitCnt <= 5'h00;
      frameDone <= 1'b0;
      frame <= 16'h0000;
      spiMiso <= 1'b0;
      pendingCode <= 6'h00;
    end
    else
    begin
      sclkPrev <= sclkS;
      csPrev <= csS;
      frameDone <= 1'b0;
      if (frameStart)
      begin
        // code is frozen at frame start so the reply cannot tear mid-shift
        pendingCode <= lfsr[5:0];
        txShift <= {10'h000, lfsr[5:0]};
        spiMiso <= 1'b0;
        bitCnt <= 5'h00;
      end
      else if (sclkRise)
      begin
        rxShift <= {rxShift[14:0], mosiS};
        if (bitCnt != 5'h1F)
        begin
          bitCnt <= bitCnt + 5'h01;
        end
      end
      else if (sclkFall)
      begin
        txShift <= {txShift[14:0], 1'b0};
        spiMiso <= txShift[14];
      end
      // frames of any other length are dropped
      if (frameEnd)
      begin
        frameDone <= (bitCnt == 5'h10);
        frame <= rxShift;
      end
    end
  end

  // free-running random source
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lfsr <= `LFSR_SEED;
    end
    else
    begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // register writes, secured mode changes and safe output
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      miscSetup <= `MISC_RESET;
      specialMode <= `SPE_RESET;
      issuedCode <= 6'h00;
      codeValid <= 1'b0;
      deviceMode <= `MODE_INIT;
      safe_n <= 1'b1;
      lpEnter <= 1'b0;
    end
    else
    begin
      lpEnter <= 1'b0;
      // a setup write in any other mode falls through unchanged
      if (miscWrite && deviceMode == `MODE_INIT)
      begin
        miscSetup <= frame[7:0];
      end
      if (codeRead)
      begin
        issuedCode <= pendingCode;
        codeValid <= 1'b1;
      end
      else if (speWrite)
      begin
        // one code serves one attempt, matched or not
        codeValid <= 1'b0;
        specialMode <= frame[7:0];
        if (modeMatch)
        begin
          case (sel)
            `SEL_RESET: deviceMode <= `MODE_RESET;
            `SEL_INIT: deviceMode <= `MODE_INIT;
            `SEL_FLASH: deviceMode <= `MODE_FLASH;
            default: deviceMode <= deviceMode;
          endcase
        end
        else if (safeMatch && sel == `SEL_INIT && deviceMode == `MODE_INIT)
        begin
          safe_n <= 1'b0;
        end
      end
      else if (resetDone && deviceMode == `MODE_RESET)
      begin
        deviceMode <= `MODE_INIT;
      end
      else if (initExit && deviceMode == `MODE_INIT)
      begin
        deviceMode <= `MODE_NORMAL;
      end
      if (lpRequest)
      begin
        lpEnter <= ~miscSetup[`MISC_CODE_GATE]
          | (codeValid & (lpCode == ~issuedCode[2:0]));
      end
    end
  end

  // interrupt output shaping
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      intCnt <= 15'h0000;
      intHeld <= 1'b0;
      int_n <= 1'b1;
    end
    else
    begin
      if (miscSetup[`MISC_INT_LEVEL])
      begin
        intCnt <= 15'h0000;
        // a new request in the clear cycle keeps the line low
        if (intReq)
        begin
          intHeld <= 1'b1;
        end
        else if (intClear)
        begin
          intHeld <= 1'b0;
        end
        // follow the next held state so a clear releases the line in one cycle
        int_n <= ~(intReq | (intHeld & ~intClear));
      end
      else
      begin
        intHeld <= 1'b0;
        if (intReq)
        begin
          intCnt <= intWidth - 15'h0001;
          int_n <= 1'b0;
        end
        else if (intCnt != 15'h0000)
        begin
          intCnt <= intCnt - 15'h0001;
        end
        else
        begin
          int_n <= 1'b1;
        end
      end
    end
  end

  // debug resistor check and safe variant selection
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dbgResFlag <= 1'b0;
      safeVariant <= 2'h0;
    end
    else
    begin
      if (dbgEn && detectedRes != miscSetup[1:0])
      begin
        dbgResFlag <= 1'b1;
      end
      else if (dbgFlagClear)
      begin
        dbgResFlag <= 1'b0;
      end
      // 00 b3, 01 b2, 10 b1, 11 a
      safeVariant <= dbgEn ? miscSetup[1:0] : detectedRes;
    end
  end
endmodule // sbc_misc_regs
`default_nettype wire

// ==== test/sbc_misc_regs_props.sv ====
// concurrent checks on the setup and special-mode register block
`timescale 1ns/1ns
`default_nettype none
module sbc_misc_regs_props #(
  parameter INT_LONG_CYC = 40,
  parameter INT_SHORT_CYC = 10
) (
  input wire clk,
  input wire arst_n,
  input wire lpRequest,
  input wire intEvent,
  input wire intClear,
  input wire wdHalf,
  input wire [1:0] detectedRes,
  input wire lpEnter,
  input wire int_n,
  input wire safe_n,
  input wire dbgResFlag,
  input wire [1:0] safeVariant,
  input wire [1:0] deviceMode,
  input wire [7:0] miscSetup
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire flashHit = wdHalf & (deviceMode == 2'h2) & miscSetup[3];
  integer cnt;
  // cycles since the last trigger, so a retrigger restarts the width count
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      cnt <= 0;
    else
      cnt <= (intEvent | flashHit) ? 1 : cnt + 1;
  lp_grant_a: assert property (lpRequest && !miscSetup[7] |=> lpEnter)
    else $error("low-power request not granted");
  lp_idle_a: assert property (!lpRequest |=> !lpEnter)
    else $error("low-power grant without request");
  int_start_a: assert property (intEvent |=> !int_n)
    else $error("interrupt not asserted");
  int_flash_a: assert property (flashHit |=> !int_n)
    else $error("flash half-period interrupt missing");
  int_width_a: assert property ($rose(int_n) && !miscSetup[5]
    |-> cnt == (miscSetup[4] ? INT_SHORT_CYC : INT_LONG_CYC) + 1)
    else $error("interrupt pulse width wrong");
  int_hold_a: assert property (miscSetup[5] && !int_n && !intClear |=> !int_n)
    else $error("held interrupt released early");
  safe_keep_a: assert property (!safe_n |=> !safe_n)
    else $error("safe output released");
  dbg_flag_a: assert property (miscSetup[2] && detectedRes != miscSetup[1:0] |=> dbgResFlag)
    else $error("debug resistor flag not set");
  variant_pick_a: assert property (miscSetup[2] && $stable(miscSetup)
    |-> safeVariant == miscSetup[1:0])
    else $error("programmed variant not applied");
  misc_lock_a: assert property (deviceMode != 2'h1 |=> $stable(miscSetup))
    else $error("setup changed outside init mode");
endmodule // sbc_misc_regs_props
bind sbc_misc_regs sbc_misc_regs_props #(.INT_LONG_CYC(INT_LONG_CYC),
  .INT_SHORT_CYC(INT_SHORT_CYC)) i_props (.clk(clk), .arst_n(arst_n),
  .lpRequest(lpRequest), .intEvent(intEvent), .intClear(intClear), .wdHalf(wdHalf),
  .detectedRes(detectedRes), .lpEnter(lpEnter), .int_n(int_n), .safe_n(safe_n),
  .dbgResFlag(dbgResFlag), .safeVariant(safeVariant), .deviceMode(deviceMode),
  .miscSetup(miscSetup));
`default_nettype wire

// ==== test/spi_host_model.sv ====
// host model: mode 0 spi master, msb first, 32 ns link clock
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  output logic spiCs_n,
  output logic spiClk,
  output logic spiMosi,
  input wire logic spiMiso
);
  initial
  begin
    spiCs_n = 1'b1;
    spiClk = 1'b0;
    spiMosi = 1'b0;
  end
  // clock idles low between frames; data is inverted once released
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    spiCs_n = 1'b0;
    for (int k = 15; k >= 0; k--)
    begin
      spiMosi = w[k];
      #16 spiClk = 1'b1;
      #15 r[k] = spiMiso;
      #1 spiClk = 1'b0;
    end
    #16 spiCs_n = 1'b1;
    spiMosi = ~spiMosi;
    #48;
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== test/sbc_init_misc_and_special_mode_regs_bench.sv ====
// self-checking bench for the setup and special-mode register block
`timescale 1ns/1ns
`default_nettype none
module sbc_init_misc_and_special_mode_regs_bench;
  logic clk, arst_n, resetDone, initExit, lpRequest, intEvent, intClear, wdHalf, dbgFlagClear;
  logic [2:0] lpCode;
  logic [1:0] detectedRes;
  logic [15:0] rx;
  logic [5:0] code;
  wire spiCs_n, spiClk, spiMosi, spiMiso, lpEnter, int_n, safe_n, dbgResFlag;
  wire [1:0] safeVariant, deviceMode;
  wire [7:0] miscSetup, specialMode;
  integer fails = 0, n_compared = 0, par = 0, i, n;
  spi_host_model host (.spiCs_n(spiCs_n), .spiClk(spiClk), .spiMosi(spiMosi),
    .spiMiso(spiMiso));
  sbc_misc_regs #(.INT_LONG_CYC(40), .INT_SHORT_CYC(10)) i_dut (.clk(clk), .arst_n(arst_n),
    .spiCs_n(spiCs_n), .spiClk(spiClk), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .resetDone(resetDone), .initExit(initExit), .lpRequest(lpRequest), .lpCode(lpCode),
    .intEvent(intEvent), .intClear(intClear), .wdHalf(wdHalf), .detectedRes(detectedRes),
    .dbgFlagClear(dbgFlagClear), .lpEnter(lpEnter), .int_n(int_n), .safe_n(safe_n),
    .dbgResFlag(dbgResFlag), .safeVariant(safeVariant), .deviceMode(deviceMode),
    .miscSetup(miscSetup), .specialMode(specialMode));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] cmd, input logic [7:0] d);
    host.xfer({cmd, par[0] & ^{cmd, d}, d}, rx);
    // realign to the falling edge so a following pulse spans a full cycle
    @(negedge clk);
  endtask
  task automatic rd;
    host.xfer(16'h1300, rx);
    @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic spe(input logic [1:0] sel, input logic [5:0] xm, input logic [1:0] m);
    rd;
    code = rx[5:0];
    check(rx[15:6], 10'h000);
    wr(7'h29, {sel, code ^ xm});
    check(deviceMode, m);
    check(specialMode, {sel, code ^ xm});
  endtask
  task automatic t_int;
    for (i = 0; i < 2; i++)
    begin
      wr(7'h28, i ? 8'h10 : 8'h00);
      pulse(intEvent);
      n = 0;
      while (int_n === 1'b0 && n < 100)
      begin
        n++;
        @(negedge clk);
      end
      check(n, i ? 10 : 40);
    end
    wr(7'h28, 8'h20);
    pulse(intEvent);
    repeat (60) @(negedge clk);
    check(int_n, 1'b0);
    pulse(intClear);
    check(int_n, 1'b1);
    $display("interrupt test done");
  endtask
  task automatic t_dbg;
    for (i = 0; i < 4; i++)
    begin
      wr(7'h28, 8'h04 | i[7:0]);
      pulse(dbgFlagClear);
      @(negedge clk);
      check(safeVariant, i[1:0]);
      check(dbgResFlag, i != 0);
    end
    wr(7'h28, 8'h00);
    check(dbgResFlag, 1'b1);
    pulse(dbgFlagClear);
    check(dbgResFlag, 1'b0);
    detectedRes = 2'h2;
    @(negedge clk);
    check(safeVariant, 2'h2);
    $display("debug resistor test done");
  endtask
  task automatic t_lp;
    pulse(lpRequest);
    check(lpEnter, 1'b1);
    wr(7'h28, 8'hC0);
    par = 1;
    host.xfer({7'h28, 1'b1, 8'h00}, rx);
    @(negedge clk);
    check(miscSetup, 8'hC0);
    rd;
    lpCode = rx[2:0];
    pulse(lpRequest);
    check(lpEnter, 1'b0);
    lpCode = ~rx[2:0];
    pulse(lpRequest);
    check(lpEnter, 1'b1);
    wr(7'h28, 8'h08);
    par = 0;
    check(miscSetup, 8'h08);
    $display("low-power and parity test done");
  endtask
  task automatic t_mode;
    pulse(wdHalf);
    check(int_n, 1'b1);
    spe(2'h2, 6'h3F, 2'h2);
    pulse(wdHalf);
    check(int_n, 1'b0);
    spe(2'h3, 6'h3F, 2'h2);
    spe(2'h1, 6'h00, 2'h2);
    wr(7'h28, 8'h00);
    check(miscSetup, 8'h08);
    spe(2'h0, 6'h3F, 2'h0);
    pulse(resetDone);
    spe(2'h1, 6'h0F, 2'h1);
    check(safe_n, 1'b0);
    pulse(initExit);
    check(deviceMode, 2'h3);
    wr(7'h28, 8'h00);
    check(miscSetup, 8'h08);
    spe(2'h1, 6'h3F, 2'h1);
    wr(7'h28, 8'h00);
    check(miscSetup, 8'h00);
    $display("special mode test done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    {arst_n, resetDone, initExit, lpRequest, intEvent, intClear, wdHalf, dbgFlagClear} = 8'h00;
    lpCode = 3'h0;
    detectedRes = 2'h0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    check(miscSetup, 8'h00);
    check(specialMode, 8'h00);
    check(int_n, 1'b1);
    t_int;
    t_dbg;
    t_lp;
    t_mode;
    complete_run;
  end
  initial
  begin
    #200000;
    fails++;
    complete_run;
  end
endmodule // sbc_init_misc_and_special_mode_regs_bench
`default_nettype wire
